/* include/sto_eval_consts.vh */
// register offsets, field positions, reset values and timing for the torque-off evaluator
`ifndef STO_EVAL_CONSTS_VH
`define STO_EVAL_CONSTS_VH

`define OFS_PW_ENTRY    8'h00
`define OFS_NEW_PW      8'h04
`define OFS_CONFIRM_PW  8'h08
`define OFS_COMM_FILTER 8'h0c
`define OFS_DRIVE_RST   8'h10
`define OFS_SAFETY_EN   8'h14
`define OFS_TOL_TIME    8'h18
`define OFS_FS_DEB      8'h1c
`define OFS_STD_DEB     8'h20
`define OFS_STATUS      8'h24
`define OFS_IRQ_STATUS  8'h28
`define OFS_IRQ_MASK    8'h2c
`define OFS_CHG_LIMIT   8'h30

`define ST_TORQUE_OFF   0
`define ST_CH_A         1
`define ST_CH_B         2
`define ST_UNLOCKED     3
`define ST_RST_BUSY     4
`define ST_MISMATCH     5

`define IRQ_DISC_FAULT  0
`define IRQ_CHG_FAULT   1
`define IRQ_WR_REJECT   2
`define IRQ_STO_SELECT  3

`define RST_PW_ENTRY    32'h0000_0000
`define RST_PW_STORED   32'h0000_0000
`define RST_COMM_FILTER 8'h00
`define COMM_READY      8'h00
`define COMM_SAFETY     8'h5f
`define DRV_RST_IDLE    8'h00
`define DRV_RST_SAFETY  8'h05
`define RST_SAFETY_EN   1'b0
`define RST_TOL_MS      16'h01f4
`define RST_FS_DEB_MS   16'h0001
`define RST_STD_DEB_MS  16'h0004
`define RST_CHG_LIMIT   8'h08
`define RST_IRQ_MASK    4'h0

`define MS_TIME_NS      1000000
`define CLK_PERIOD_NS   4
`define CHG_WINDOW_MS   16'h0064
`define RST_CYCLES      3'h4

`endif

/* logic/safe_torque_off_input_eval.v */
// two-channel fail-safe input evaluator for safe torque off, with apb settings
// Operation
// - safety settings change only after correct password
// - entry resets zero, passwords 1..ffffffff
// - filter 0 ready, 95 safety commissioning
// - writing 5 resets safety settings, self-clears
// - factory reset leaves standard settings alone
// - enable resets 0; 1 enables terminal functions
// - status bit high while torque off
// - compare both channels continuously
// - tolerate mismatch up to tolerance time
// - persistent mismatch reports wiring fault
// - high-to-low on either channel selects torque off
// - suppress changes shorter than debounce time
// - selection waits for debounce time
// - too many changes per window faults
// - standard and fail-safe debounce independent
// - torque removed and brake closed
`include "sto_eval_consts.vh"
`timescale 1ns/100ps

module safe_torque_off_input_eval #(
  parameter MS_CYCLES = `MS_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        fs_in_a,
  input  wire        fs_in_b,
  input  wire        std_din,
  output wire        std_din_filtered,
  output wire        torque_off_active_flag,
  output wire        torque_enable,
  output wire        brake_close,
  output wire        irq
);

  localparam RS_IDLE = 1'b0;
  localparam RS_BUSY = 1'b1;

  reg  [31:0] prdata_reg;
  reg         pready_reg;
  reg         pslverr_reg;
  reg  [2:0]  sync1_reg;
  reg  [2:0]  sync2_reg;
  reg  [1:0]  prev_reg;
  reg  [31:0] tick_cnt_reg;
  reg         tick_reg;
  reg  [31:0] pw_entry_reg;
  reg  [31:0] pw_stored_reg;
  reg  [31:0] new_pw_reg;
  reg  [7:0]  comm_reg;
  reg  [7:0]  drv_rst_reg;
  reg         rs_state_reg;
  reg  [2:0]  rs_cnt_reg;
  reg         enable_reg;
  reg  [15:0] tol_reg;
  reg  [15:0] fs_deb_reg;
  reg  [15:0] std_deb_reg;
  reg  [7:0]  chg_lim_reg;
  reg  [3:0]  irq_st_reg;
  reg  [3:0]  irq_mask_reg;
  reg  [15:0] disc_cnt_reg;
  reg  [15:0] win_cnt_reg;
  reg  [7:0]  chg_cnt_reg;
  reg         sto_reg;
  reg         torque_en_reg;
  reg         brake_reg;
  reg         irq_reg;
  reg  [31:0] rdata;
  reg         err;
  reg  [3:0]  irq_next;
  reg  [7:0]  chg_next;
  reg         sto_next;

  wire [2:0]  filt;
  wire        capture;
  wire        wr_do;
  wire        wr_rej;
  wire        unlocked;
  wire        safety_ok;
  wire        mismatch;
  wire        disc_ev;
  wire        chg_ev;
  wire [1:0]  edges;

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign prdata                 = prdata_reg;
  assign pready                 = pready_reg;
  assign pslverr                = pslverr_reg;
  assign std_din_filtered       = filt[2];
  assign torque_off_active_flag = sto_reg;
  assign torque_enable          = torque_en_reg;
  assign brake_close            = brake_reg;
  assign irq                    = irq_reg;

  // apb: one wait state, answer on second access cycle
  assign capture = psel & penable & ~pready_reg;
  assign wr_do   = psel & penable & pready_reg & pwrite & ~err;
  assign wr_rej  = psel & penable & pready_reg & pwrite & err;

  // factory stored value means no password set
  assign unlocked  = (pw_stored_reg == `RST_PW_STORED) || (pw_entry_reg == pw_stored_reg);
  assign safety_ok = unlocked && (comm_reg == `COMM_SAFETY);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= capture;
      pslverr_reg <= capture & err;
      if (capture) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rdata;
      end
    end
  end

  always @* begin
    err = 1'b0;
    if (hit(paddr, `OFS_PW_ENTRY)) begin
      err = 1'b0;
    end else if (hit(paddr, `OFS_COMM_FILTER)) begin
      err = pwrite && (pwdata != {24'h0, `COMM_READY}) && (pwdata != {24'h0, `COMM_SAFETY});
    end else if (hit(paddr, `OFS_NEW_PW)) begin
      err = pwrite && !safety_ok;
    end else if (hit(paddr, `OFS_CONFIRM_PW)) begin
      err = pwrite && (!safety_ok || (pwdata != new_pw_reg) || (pwdata == 32'h0000_0000));
    end else if (hit(paddr, `OFS_DRIVE_RST)) begin
      err = pwrite && (pwdata != {24'h0, `DRV_RST_IDLE}) &&
            ((pwdata != {24'h0, `DRV_RST_SAFETY}) || !safety_ok || (rs_state_reg == RS_BUSY));
    end else if (hit(paddr, `OFS_SAFETY_EN) || hit(paddr, `OFS_TOL_TIME) ||
                 hit(paddr, `OFS_FS_DEB) || hit(paddr, `OFS_CHG_LIMIT)) begin
      err = pwrite && (!safety_ok || (rs_state_reg == RS_BUSY));
    end else if (hit(paddr, `OFS_STD_DEB) || hit(paddr, `OFS_IRQ_STATUS) ||
                 hit(paddr, `OFS_IRQ_MASK)) begin
      err = 1'b0;
    end else if (hit(paddr, `OFS_STATUS)) begin
      err = pwrite;
    end else begin
      err = 1'b1;
    end
  end

  always @* begin
    rdata = 32'h0000_0000;
    if (hit(paddr, `OFS_COMM_FILTER)) begin
      rdata = {24'h0, comm_reg};
    end else if (hit(paddr, `OFS_DRIVE_RST)) begin
      rdata = {24'h0, drv_rst_reg};
    end else if (hit(paddr, `OFS_SAFETY_EN)) begin
      rdata = {31'h0, enable_reg};
    end else if (hit(paddr, `OFS_TOL_TIME)) begin
      rdata = {16'h0, tol_reg};
    end else if (hit(paddr, `OFS_FS_DEB)) begin
      rdata = {16'h0, fs_deb_reg};
    end else if (hit(paddr, `OFS_STD_DEB)) begin
      rdata = {16'h0, std_deb_reg};
    end else if (hit(paddr, `OFS_STATUS)) begin
      rdata[`ST_TORQUE_OFF] = sto_reg;
      rdata[`ST_CH_A]       = filt[0];
      rdata[`ST_CH_B]       = filt[1];
      rdata[`ST_UNLOCKED]   = unlocked;
      rdata[`ST_RST_BUSY]   = (rs_state_reg == RS_BUSY);
      rdata[`ST_MISMATCH]   = mismatch;
    end else if (hit(paddr, `OFS_IRQ_STATUS)) begin
      rdata = {28'h0, irq_st_reg};
    end else if (hit(paddr, `OFS_IRQ_MASK)) begin
      rdata = {28'h0, irq_mask_reg};
    end else if (hit(paddr, `OFS_CHG_LIMIT)) begin
      rdata = {24'h0, chg_lim_reg};
    end
  end

  // password and settings, factory reset sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_entry_reg  <= `RST_PW_ENTRY;
      pw_stored_reg <= `RST_PW_STORED;
      new_pw_reg    <= 32'h0000_0000;
      comm_reg      <= `RST_COMM_FILTER;
      drv_rst_reg   <= `DRV_RST_IDLE;
      rs_state_reg  <= RS_IDLE;
      rs_cnt_reg    <= 3'h0;
      enable_reg    <= `RST_SAFETY_EN;
      tol_reg       <= `RST_TOL_MS;
      fs_deb_reg    <= `RST_FS_DEB_MS;
      std_deb_reg   <= `RST_STD_DEB_MS;
      chg_lim_reg   <= `RST_CHG_LIMIT;
      irq_mask_reg  <= `RST_IRQ_MASK;
    end else begin
      if (wr_do) begin
        if (hit(paddr, `OFS_PW_ENTRY)) begin
          pw_entry_reg <= pwdata;
        end else if (hit(paddr, `OFS_NEW_PW)) begin
          new_pw_reg <= pwdata;
        end else if (hit(paddr, `OFS_CONFIRM_PW)) begin
          pw_stored_reg <= pwdata;
          pw_entry_reg  <= pwdata;
        end else if (hit(paddr, `OFS_COMM_FILTER)) begin
          comm_reg <= pwdata[7:0];
        end else if (hit(paddr, `OFS_SAFETY_EN)) begin
          enable_reg <= pwdata[0];
        end else if (hit(paddr, `OFS_TOL_TIME)) begin
          tol_reg <= pwdata[15:0];
        end else if (hit(paddr, `OFS_FS_DEB)) begin
          fs_deb_reg <= pwdata[15:0];
        end else if (hit(paddr, `OFS_STD_DEB)) begin
          std_deb_reg <= pwdata[15:0];
        end else if (hit(paddr, `OFS_IRQ_MASK)) begin
          irq_mask_reg <= pwdata[3:0];
        end else if (hit(paddr, `OFS_CHG_LIMIT)) begin
          chg_lim_reg <= pwdata[7:0];
        end
      end
      case (rs_state_reg)
        RS_IDLE: begin
          if (wr_do && hit(paddr, `OFS_DRIVE_RST) && (pwdata[7:0] == `DRV_RST_SAFETY)) begin
            drv_rst_reg  <= `DRV_RST_SAFETY;
            rs_cnt_reg   <= 3'h0;
            rs_state_reg <= RS_BUSY;
          end
        end
        RS_BUSY: begin
          if (rs_cnt_reg == `RST_CYCLES - 3'h1) begin
            // safety settings only; standard debounce kept
            enable_reg   <= `RST_SAFETY_EN;
            tol_reg      <= `RST_TOL_MS;
            fs_deb_reg   <= `RST_FS_DEB_MS;
            chg_lim_reg  <= `RST_CHG_LIMIT;
            drv_rst_reg  <= `DRV_RST_IDLE;
            rs_state_reg <= RS_IDLE;
          end else begin
            rs_cnt_reg <= rs_cnt_reg + 3'h1;
          end
        end
        default: begin
          rs_state_reg <= RS_IDLE;
        end
      endcase
    end
  end

  // pin synchronisers and millisecond tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg    <= 3'h0;
      sync2_reg    <= 3'h0;
      prev_reg     <= 2'h0;
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
    end else begin
      sync1_reg <= {std_din, fs_in_b, fs_in_a};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg[1:0];
      if (tick_cnt_reg == MS_CYCLES - 1) begin
        tick_cnt_reg <= 32'h0000_0000;
        tick_reg     <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
        tick_reg     <= 1'b0;
      end
    end
  end

  // debounce: level taken only after stable for its own time
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : deb
      wire [15:0] deb_t = (i == 2) ? std_deb_reg : fs_deb_reg;
      reg         filt_reg;
      reg  [15:0] cnt_reg;
      assign filt[i] = filt_reg;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          filt_reg <= 1'b0;
          cnt_reg  <= 16'h0000;
        end else if (sync2_reg[i] == filt_reg) begin
          cnt_reg <= 16'h0000;
        end else if (cnt_reg >= deb_t) begin
          filt_reg <= sync2_reg[i];
          cnt_reg  <= 16'h0000;
        end else if (tick_reg) begin
          cnt_reg <= cnt_reg + 16'h1;
        end
      end
    end
  endgenerate

  // discrepancy and change-rate monitoring
  assign mismatch = filt[0] ^ filt[1];
  assign disc_ev  = mismatch && (disc_cnt_reg > tol_reg);
  assign edges    = sync2_reg[1:0] ^ prev_reg;
  assign chg_ev   = chg_cnt_reg > chg_lim_reg;

  always @* begin
    chg_next = chg_cnt_reg;
    if (tick_reg && (win_cnt_reg == `CHG_WINDOW_MS - 16'h1)) begin
      chg_next = 8'h00;
    end
    if ((chg_next != 8'hff) && (edges != 2'h0)) begin
      chg_next = chg_next + {7'h0, edges[0]} + {7'h0, edges[1]};
      if (chg_next < chg_cnt_reg) begin
        chg_next = 8'hff;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disc_cnt_reg <= 16'h0000;
      win_cnt_reg  <= 16'h0000;
      chg_cnt_reg  <= 8'h00;
    end else begin
      if (!mismatch) begin
        disc_cnt_reg <= 16'h0000;
      end else if (tick_reg && (disc_cnt_reg != 16'hffff)) begin
        disc_cnt_reg <= disc_cnt_reg + 16'h1;
      end
      if (tick_reg) begin
        if (win_cnt_reg == `CHG_WINDOW_MS - 16'h1) begin
          win_cnt_reg <= 16'h0000;
        end else begin
          win_cnt_reg <= win_cnt_reg + 16'h1;
        end
      end
      chg_cnt_reg <= chg_next;
    end
  end

  // torque-off decision; faults hold it until cleared
  always @* begin
    if (!enable_reg) begin
      sto_next = 1'b0;
    end else begin
      sto_next = ~filt[0] | ~filt[1] | irq_st_reg[`IRQ_DISC_FAULT] |
                 irq_st_reg[`IRQ_CHG_FAULT];
    end
  end

  always @* begin
    irq_next = irq_st_reg;
    if (wr_do && hit(paddr, `OFS_IRQ_STATUS)) begin
      irq_next = irq_st_reg & ~pwdata[3:0];
    end
    // new events win over a clear in the same cycle
    irq_next[`IRQ_DISC_FAULT] = irq_next[`IRQ_DISC_FAULT] | (enable_reg & disc_ev);
    irq_next[`IRQ_CHG_FAULT]  = irq_next[`IRQ_CHG_FAULT] | (enable_reg & chg_ev);
    irq_next[`IRQ_WR_REJECT]  = irq_next[`IRQ_WR_REJECT] | wr_rej;
    irq_next[`IRQ_STO_SELECT] = irq_next[`IRQ_STO_SELECT] | (sto_next & ~sto_reg);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_reg    <= 4'h0;
      irq_reg       <= 1'b0;
      sto_reg       <= 1'b0;
      torque_en_reg <= 1'b0;
      brake_reg     <= 1'b1;
    end else begin
      irq_st_reg    <= irq_next;
      irq_reg       <= |(irq_next & irq_mask_reg);
      sto_reg       <= sto_next;
      torque_en_reg <= ~sto_next;
      brake_reg     <= sto_next;
    end
  end

endmodule

/* sim/failsafe_sensor_model.sv */
// safety sensor model: two contacts plus a short output test pulse
`timescale 1ns/100ps
module failsafe_sensor_model #(
  parameter [7:0] PULSE_CYCLES = 8'h05
) (
  input  wire pclk,
  input  wire contact_a,
  input  wire contact_b,
  input  wire pulse_req,
  output reg  fs_in_a,
  output reg  fs_in_b
);
  reg [7:0] pulse_cnt;
  initial begin
    pulse_cnt = 8'h00;
    fs_in_a = 1'b0;
    fs_in_b = 1'b0;
  end
  // test pulse drops both outputs, kept shorter than the debounce time
  always @(posedge pclk) begin
    if (pulse_req && pulse_cnt == 8'h00)
      pulse_cnt <= PULSE_CYCLES;
    else if (pulse_cnt != 8'h00)
      pulse_cnt <= pulse_cnt - 8'h01;
    fs_in_a <= contact_a && (pulse_cnt == 8'h00);
    fs_in_b <= contact_b && (pulse_cnt == 8'h00);
  end
endmodule

/* sim/sto_eval_monitor.sv */
// port-level checker for the torque-off evaluator
`timescale 1ns/100ps
module sto_eval_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        fs_in_a,
  input wire        fs_in_b,
  input wire        std_din,
  input wire        std_din_filtered,
  input wire        torque_off_active_flag,
  input wire        torque_enable,
  input wire        brake_close,
  input wire        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after wait state");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_rdata_held: assert property (!(psel && penable && !pready) |=> $stable(prdata))
    else $error("prdata changed without capture");
  a_enable_inverse: assert property ($past(presetn) |-> torque_enable != torque_off_active_flag)
    else $error("torque enable not inverse of flag");
  a_brake_follows: assert property ($past(presetn) |-> brake_close == torque_off_active_flag)
    else $error("brake not following flag");
  a_std_settled: assert property ($changed(std_din_filtered) |->
    std_din_filtered == $past(std_din, 3) && std_din_filtered == $past(std_din, 20))
    else $error("standard input passed unsettled");
endmodule
bind safe_torque_off_input_eval sto_eval_monitor mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .fs_in_a(fs_in_a), .fs_in_b(fs_in_b),
  .std_din(std_din), .std_din_filtered(std_din_filtered), .irq(irq),
  .torque_off_active_flag(torque_off_active_flag), .torque_enable(torque_enable),
  .brake_close(brake_close));

/* sim/testbench.sv */
// self-checking bench for the torque-off evaluator
`include "sto_eval_consts.vh"
`timescale 1ns/100ps
module testbench;
  localparam MS = 10;
  reg         pclk, presetn, psel, penable, pwrite, std_din;
  reg         contact_a, contact_b, pulse_req, err;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, fs_in_a, fs_in_b, std_din_filtered;
  wire        torque_off_active_flag, torque_enable, brake_close, irq;
  integer     errors, n_tests, i, k;
  reg  [39:0] row;
  failsafe_sensor_model sensor (.pclk(pclk), .contact_a(contact_a), .contact_b(contact_b),
    .pulse_req(pulse_req), .fs_in_a(fs_in_a), .fs_in_b(fs_in_b));
  safe_torque_off_input_eval #(.MS_CYCLES(MS)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fs_in_a(fs_in_a),
    .fs_in_b(fs_in_b), .std_din(std_din), .std_din_filtered(std_din_filtered),
    .torque_off_active_flag(torque_off_active_flag), .torque_enable(torque_enable),
    .brake_close(brake_close), .irq(irq));
  always #2 pclk = ~pclk;
  task print_verdict;
    begin
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task check(input [8*10-1:0] name, input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  task timeout;
    begin
      errors = errors + 1;
      print_verdict;
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      // request held until pready is sampled high at a rising edge
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20) begin
        @(posedge pclk);
        k = k + 1;
      end
      if (k == 20)
        timeout;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input e);
    begin
      apb(1'b1, a, d);
      check("wr_refuse", {31'h0, err}, {31'h0, e});
    end
  endtask
  task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      check("read", rd & m, e);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task wait_flag(input v, input integer lim);
    begin
      k = 0;
      while (torque_off_active_flag !== v && k < lim) begin
        @(negedge pclk);
        k = k + 1;
      end
      if (k == lim)
        timeout;
      @(posedge pclk);
    end
  endtask
  function [39:0] rst_row(input integer n);
    case (n)
      0: rst_row = {`OFS_PW_ENTRY, 32'h0000_0000};
      1: rst_row = {`OFS_COMM_FILTER, 32'h0000_0000};
      2: rst_row = {`OFS_SAFETY_EN, 32'h0000_0000};
      3: rst_row = {`OFS_TOL_TIME, 32'h0000_01f4};
      4: rst_row = {`OFS_FS_DEB, 32'h0000_0001};
      5: rst_row = {`OFS_STD_DEB, 32'h0000_0004};
      6: rst_row = {`OFS_IRQ_MASK, 32'h0000_0000};
      default: rst_row = {`OFS_CHG_LIMIT, 32'h0000_0008};
    endcase
  endfunction
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, std_din, pulse_req, err} = 6'h00;
    {contact_a, contact_b} = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0;
    rd = 32'h0;
    errors = 0;
    n_tests = 0;
    cyc(3);
    presetn <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      row = rst_row(i);
      rdc(row[39:32], 32'hffff_ffff, row[31:0]);
    end
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    wr(`OFS_STATUS, 32'h1, 1'b1);
    wr(`OFS_SAFETY_EN, 32'h1, 1'b1);
    wr(`OFS_COMM_FILTER, 32'h7, 1'b1);
    wr(`OFS_COMM_FILTER, 32'h5f, 1'b0);
    wr(`OFS_NEW_PW, 32'h0, 1'b0);
    wr(`OFS_CONFIRM_PW, 32'h0, 1'b1);
    wr(`OFS_NEW_PW, 32'h1234_5678, 1'b0);
    wr(`OFS_CONFIRM_PW, 32'h1234_5679, 1'b1);
    wr(`OFS_CONFIRM_PW, 32'h1234_5678, 1'b0);
    wr(`OFS_PW_ENTRY, 32'h0, 1'b0);
    wr(`OFS_SAFETY_EN, 32'h1, 1'b1);
    wr(`OFS_PW_ENTRY, 32'h1234_5678, 1'b0);
    wr(`OFS_SAFETY_EN, 32'h1, 1'b0);
    wr(`OFS_FS_DEB, 32'h2, 1'b0);
    wr(`OFS_TOL_TIME, 32'h5, 1'b0);
    wr(`OFS_STD_DEB, 32'h7, 1'b0);
    wait_flag(1'b0, 200);
    rdc(`OFS_STATUS, 32'h1, 32'h0);
    pulse_req <= 1'b1;
    cyc(1);
    pulse_req <= 1'b0;
    cyc(40);
    check("pulse_sup", {31'h0, torque_off_active_flag}, 32'h0);
    contact_a <= 1'b0;
    wait_flag(1'b1, 60);
    check("deb_delay", {31'h0, k >= MS}, 32'h1);
    rdc(`OFS_STATUS, 32'h1, 32'h1);
    contact_a <= 1'b1;
    wait_flag(1'b0, 100);
    wr(`OFS_IRQ_STATUS, 32'hf, 1'b0);
    for (i = 0; i < 2; i = i + 1) begin
      contact_b <= 1'b0;
      cyc(30);
      check("sel_b", {31'h0, torque_off_active_flag}, 32'h1);
      contact_b <= 1'b1;
      cyc(60);
    end
    rdc(`OFS_IRQ_STATUS, 32'h1, 32'h0);
    contact_b <= 1'b0;
    cyc(150);
    contact_b <= 1'b1;
    cyc(60);
    rdc(`OFS_IRQ_STATUS, 32'h1, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h1, 1'b0);
    // new mask reaches irq one edge after the write edge
    cyc(1);
    @(negedge pclk);
    check("irq_set", {31'h0, irq}, 32'h1);
    check("fault_hold", {31'h0, torque_off_active_flag}, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h1, 1'b0);
    @(negedge pclk);
    check("irq_clr", {31'h0, irq}, 32'h0);
    wr(`OFS_IRQ_STATUS, 32'hf, 1'b0);
    for (i = 0; i < 10; i = i + 1) begin
      pulse_req <= 1'b1;
      cyc(1);
      pulse_req <= 1'b0;
      cyc(19);
    end
    rdc(`OFS_IRQ_STATUS, 32'h2, 32'h2);
    std_din <= 1'b1;
    cyc(5);
    std_din <= 1'b0;
    cyc(120);
    check("std_glitch", {31'h0, std_din_filtered}, 32'h0);
    std_din <= 1'b1;
    cyc(120);
    check("std_level", {31'h0, std_din_filtered}, 32'h1);
    wr(`OFS_DRIVE_RST, 32'h5, 1'b0);
    i = 0;
    rd = 32'h1;
    while (rd !== 32'h0 && i < 20) begin
      apb(1'b0, `OFS_DRIVE_RST, 32'h0);
      i = i + 1;
    end
    if (i == 20)
      timeout;
    rdc(`OFS_SAFETY_EN, 32'hffff_ffff, 32'h0);
    rdc(`OFS_TOL_TIME, 32'hffff_ffff, 32'h1f4);
    rdc(`OFS_FS_DEB, 32'hffff_ffff, 32'h1);
    rdc(`OFS_STD_DEB, 32'hffff_ffff, 32'h7);
    rdc(`OFS_COMM_FILTER, 32'hffff_ffff, 32'h5f);
    print_verdict;
  end
endmodule
